// >>> inc/mpp_pkg.sv
// package for the parallel port group: register map, reset values, carriers
package mpp_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_P0_LATCH   = 10'h000;
    localparam logic [9:0] IDX_P1_LATCH   = 10'h001;
    localparam logic [9:0] IDX_P2_LATCH   = 10'h002;
    localparam logic [9:0] IDX_P3_LATCH   = 10'h003;
    localparam logic [9:0] IDX_P4_LATCH   = 10'h004;
    localparam logic [9:0] IDX_P5_LATCH   = 10'h005;
    localparam logic [9:0] IDX_P0_DIR     = 10'h00A;
    localparam logic [9:0] IDX_P1_DRIVE   = 10'h00B;
    localparam logic [9:0] IDX_P4_DIR     = 10'h00C;
    localparam logic [9:0] IDX_P5_DIR     = 10'h00D;
    localparam logic [9:0] IDX_CONV_CTL1  = 10'h00E;
    localparam logic [9:0] IDX_P1_SENSE   = 10'h015;
    localparam logic [9:0] IDX_P2_SENSE   = 10'h016;
    localparam logic [9:0] IDX_P3_SENSE   = 10'h017;
    localparam logic [9:0] IDX_P4_GATE    = 10'h028;
    localparam logic [9:0] IDX_T3_POL     = 10'h029;

    // field positions
    localparam int         AIN_DIS_BIT    = 4;   // analog_input_disable in converter_control_one
    localparam int         T3_INV_BIT     = 0;   // phase invert in timer3_input_polarity

    // reset values
    localparam logic [7:0] RST_P0_LATCH   = 8'h00;
    localparam logic [7:0] RST_P0_DIR     = 8'h00;
    localparam logic [7:0] RST_P1_LATCH   = 8'hFF;
    localparam logic [7:0] RST_P1_DRIVE   = 8'h00;
    localparam logic [2:0] RST_P2_LATCH   = 3'h7;
    localparam logic [1:0] RST_P3_LATCH   = 2'h3;
    localparam logic [7:0] RST_P4_LATCH   = 8'h00;
    localparam logic [7:0] RST_P4_DIR     = 8'h00;
    localparam logic [7:0] RST_P4_GATE    = 8'hFF;
    localparam logic [3:0] RST_P5_LATCH   = 4'h0;
    localparam logic [3:0] RST_P5_DIR     = 4'h0;
    localparam logic [7:0] RST_CONV_CTL1  = 8'h10;
    localparam logic [7:0] RST_T3_POL     = 8'h00;

    // drive from the on-chip peripherals toward the pins
    typedef struct packed {
        logic timer4_pulse_width_out;  // pulse-width output
        logic timer4_divider_out;      // programmable divider output
        logic timer4_out_sel;          // 1 selects the divider output
        logic pulse_pattern_out;       // pulse pattern output
        logic serial_data_out;         // serial data out
        logic serial_clock_out_n;      // serial clock out, active low
        logic divider_out_n;           // divider output, active low
    } mpp_periph_drive_t;

    // pin levels handed to the on-chip peripherals
    typedef struct packed {
        logic timer2_input;
        logic timer3_input;            // after phase select
        logic ext_irq3;
        logic timer4_input;
        logic ext_irq4;
        logic serial_data_in;
        logic serial_clock_in_n;
        logic ext_irq0;
        logic ext_irq1;
        logic ext_irq2;
        logic timer1_input;
    } mpp_periph_sense_t;

endpackage

// >>> rtl/mpp_port_group.sv
// six parallel ports with their control registers behind an apb slave
// Summary of operation
// RULE1: outputs held in latches; inputs read live
// RULE2: pin levels sampled in first read state
// RULE3: pin output changes in second write state; here pins move in the cycle after it
// RULE4: port0 direction register; reset clears dir, latch
// RULE5: mixed-direction data read returns pins for inputs
// RULE6: port1 latch resets one, drive type zero
// RULE7: port1 per-bit open-drain or push-pull select
// RULE8: port1 data reads latch, sense reads pins
// RULE9: timer3 input phase invert select register
// RULE10: port1 bits0-4 carry timer and irq functions
// RULE11: port1 bits5-7 carry serial in, out, clock
// RULE12: port2 three bits, latch one, sense register
// RULE13: port2 bits seven to three read undefined
// RULE14: port2 bits1,2 resonator in dual clock
// RULE15: port2 bit0 high impedance in stop mode
// RULE16: port3 two bits, latch one, sense register
// RULE17: port4 direction one is output, gate enables
// RULE18: port4 reset: dir zero, gate one, latch zero
// RULE19: software clears dir then gate for analog
// RULE20: port4 gate zero blocks input, reads zero
// RULE21: port5 four bits, direction, reset to input
// RULE22: port5 bits0-2 irq/timer in, bit3 divider out
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module mpp_port_group
    import mpp_pkg::*;
(
    input  wire logic              mclk,            // system clock, 100 MHz
    input  wire logic              rst_n,           // synchronous reset, active low
    // apb slave
    input  wire logic              psel,            // slave select
    input  wire logic              penable,         // access phase
    input  wire logic              pwrite,          // 1 write, 0 read
    input  wire logic [11:0]       paddr,           // byte address
    input  wire logic [31:0]       pwdata,          // write data
    output logic      [31:0]       prdata,          // read data
    output logic                   pready,          // transfer done
    output logic                   pslverr,         // unmapped address
    // chip modes
    input  wire logic              stop_mode,       // device in stop mode
    input  wire logic              dual_clock_mode, // slow resonator fitted
    // pins, three signals each; port4 has a fourth for its input gate
    input  wire logic [7:0]        p0_in,           // port0 pin level
    output logic      [7:0]        p0_out,          // port0 drive value
    output logic      [7:0]        p0_oe,           // port0 drive enable
    input  wire logic [7:0]        p1_in,           // port1 pin level
    output logic      [7:0]        p1_out,          // port1 drive value
    output logic      [7:0]        p1_oe,           // port1 drive enable
    input  wire logic [2:0]        p2_in,           // port2 pin level
    output logic      [2:0]        p2_out,          // port2 drive value
    output logic      [2:0]        p2_oe,           // port2 drive enable
    input  wire logic [1:0]        p3_in,           // port3 pin level
    output logic      [1:0]        p3_out,          // port3 drive value
    output logic      [1:0]        p3_oe,           // port3 drive enable
    input  wire logic [7:0]        p4_in,           // port4 pin level
    output logic      [7:0]        p4_out,          // port4 drive value
    output logic      [7:0]        p4_oe,           // port4 drive enable
    output logic      [7:0]        p4_gate_open,    // digital input gate open
    input  wire logic [3:0]        p5_in,           // port5 pin level
    output logic      [3:0]        p5_out,          // port5 drive value
    output logic      [3:0]        p5_oe,           // port5 drive enable
    // peripherals
    input  wire mpp_periph_drive_t periph_drive,    // peripheral outputs
    output mpp_periph_sense_t      periph_sense,    // peripheral inputs
    output logic                   analog_input_disable // converter input off
);

    // control registers
    logic [7:0] port0_out_latch_reg;
    logic [7:0] port0_direction_reg;
    logic [7:0] port1_out_latch_reg;
    logic [7:0] port1_drive_type_reg;
    logic [2:0] port2_out_latch_reg;
    logic [1:0] port3_out_latch_reg;
    logic [7:0] port4_out_latch_reg;
    logic [7:0] port4_direction_reg;
    logic [7:0] port4_input_gate_reg;
    logic [3:0] port5_out_latch_reg;
    logic [3:0] port5_direction_reg;
    logic [7:0] converter_control_one_reg;
    logic [7:0] timer3_input_polarity_reg;

    // pin synchronisers; stage one is read only by stage two
    logic [32:0] pin_meta_reg;
    logic [32:0] pin_sync_reg;
    logic [7:0]  p0_pin;
    logic [7:0]  p1_pin;
    logic [2:0]  p2_pin;
    logic [1:0]  p3_pin;
    logic [7:0]  p4_pin;
    logic [3:0]  p5_pin;

    // bus decode
    logic [9:0]  idx;
    logic        setup_phase;
    logic        wr_access;
    logic        mapped;
    logic [7:0]  wbyte;
    logic [31:0] rdata_next;

    // next drive values
    logic [7:0]  p1_value;
    logic [2:0]  p2_value;
    logic [3:0]  p5_value;
    logic [2:0]  p2_oe_next;

    assign idx         = paddr[11:2];
    assign setup_phase = psel & ~penable;
    assign wr_access   = psel & penable & pwrite & mapped;
    assign wbyte       = pwdata[7:0];

    // two-flop synchroniser for all pin inputs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_meta_reg <= 33'h0_0000_0000;
            pin_sync_reg <= 33'h0_0000_0000;
        end else begin
            pin_meta_reg <= {p5_in, p4_in, p3_in, p2_in, p1_in, p0_in};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign p0_pin = pin_sync_reg[7:0];
    assign p1_pin = pin_sync_reg[15:8];
    assign p2_pin = pin_sync_reg[18:16];
    assign p3_pin = pin_sync_reg[20:19];
    assign p4_pin = pin_sync_reg[28:21];
    assign p5_pin = pin_sync_reg[32:29];

    // address decode
    always_comb begin
        unique case (idx)
            IDX_P0_LATCH, IDX_P1_LATCH, IDX_P2_LATCH, IDX_P3_LATCH,
            IDX_P4_LATCH, IDX_P5_LATCH, IDX_P0_DIR, IDX_P1_DRIVE,
            IDX_P4_DIR, IDX_P5_DIR, IDX_CONV_CTL1, IDX_P1_SENSE,
            IDX_P2_SENSE, IDX_P3_SENSE, IDX_P4_GATE, IDX_T3_POL: mapped = 1'b1;
            default:                                              mapped = 1'b0;
        endcase
    end

    // read mux; port0, port4, port5 data give pins for input bits, latch for output bits
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (idx)
            IDX_P0_LATCH:  rdata_next[7:0] = (port0_direction_reg & port0_out_latch_reg)
                                           | (~port0_direction_reg & p0_pin);   // [RULE5] [RULE1]
            IDX_P1_LATCH:  rdata_next[7:0] = port1_out_latch_reg;  // [RULE8]
            IDX_P2_LATCH:  rdata_next[2:0] = port2_out_latch_reg;  // [RULE13]
            IDX_P3_LATCH:  rdata_next[1:0] = port3_out_latch_reg;
            IDX_P4_LATCH:  rdata_next[7:0] = (port4_direction_reg & port4_out_latch_reg)
                                           | (~port4_direction_reg & p4_pin
                                              & port4_input_gate_reg);          // [RULE5] [RULE20]
            IDX_P5_LATCH:  rdata_next[3:0] = (port5_direction_reg & port5_out_latch_reg)
                                           | (~port5_direction_reg & p5_pin);   // [RULE5]
            IDX_P0_DIR:    rdata_next[7:0] = port0_direction_reg;
            IDX_P1_DRIVE:  rdata_next[7:0] = port1_drive_type_reg;
            IDX_P4_DIR:    rdata_next[7:0] = port4_direction_reg;
            IDX_P5_DIR:    rdata_next[3:0] = port5_direction_reg;
            IDX_CONV_CTL1: rdata_next[7:0] = converter_control_one_reg;
            IDX_P1_SENSE:  rdata_next[7:0] = p1_pin;  // [RULE8]
            IDX_P2_SENSE:  rdata_next[2:0] = p2_pin;  // [RULE12] [RULE13]
            IDX_P3_SENSE:  rdata_next[1:0] = p3_pin;  // [RULE16]
            IDX_P4_GATE:   rdata_next[7:0] = port4_input_gate_reg;  // [RULE20]
            IDX_T3_POL:    rdata_next[7:0] = timer3_input_polarity_reg;
            default:       rdata_next = 32'h0000_0000;
        endcase
    end

    // read data captured in the setup cycle, the first state of the read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_phase;  // zero wait
            pslverr <= setup_phase & ~mapped;
            if (setup_phase && !pwrite) begin
                prdata <= rdata_next;  // [RULE2]
            end
        end
    end

    // port0 registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            port0_out_latch_reg <= RST_P0_LATCH;  // [RULE4]
            port0_direction_reg <= RST_P0_DIR;  // [RULE4]
        end else if (wr_access) begin
            if (idx == IDX_P0_LATCH) port0_out_latch_reg <= wbyte;  // [RULE1]
            if (idx == IDX_P0_DIR)   port0_direction_reg <= wbyte;
        end
    end

    // port1, port2, port3 registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            port1_out_latch_reg  <= RST_P1_LATCH;  // [RULE6]
            port1_drive_type_reg <= RST_P1_DRIVE;  // [RULE6]
            port2_out_latch_reg  <= RST_P2_LATCH;  // [RULE12]
            port3_out_latch_reg  <= RST_P3_LATCH;  // [RULE16]
            timer3_input_polarity_reg <= RST_T3_POL;
        end else if (wr_access) begin
            if (idx == IDX_P1_LATCH) port1_out_latch_reg  <= wbyte;
            if (idx == IDX_P1_DRIVE) port1_drive_type_reg <= wbyte;  // [RULE7]
            if (idx == IDX_P2_LATCH) port2_out_latch_reg  <= wbyte[2:0];
            if (idx == IDX_P3_LATCH) port3_out_latch_reg  <= wbyte[1:0];
            if (idx == IDX_T3_POL)   timer3_input_polarity_reg <= wbyte;  // [RULE9]
        end
    end

    // port4, port5 and converter registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            port4_out_latch_reg       <= RST_P4_LATCH;  // [RULE18]
            port4_direction_reg       <= RST_P4_DIR;  // [RULE18]
            port4_input_gate_reg      <= RST_P4_GATE;  // [RULE18]
            port5_out_latch_reg       <= RST_P5_LATCH;  // [RULE21]
            port5_direction_reg       <= RST_P5_DIR;  // [RULE21]
            converter_control_one_reg <= RST_CONV_CTL1;
        end else if (wr_access) begin
            if (idx == IDX_P4_LATCH)  port4_out_latch_reg       <= wbyte;
            if (idx == IDX_P4_DIR)    port4_direction_reg       <= wbyte;  // [RULE17]
            if (idx == IDX_P4_GATE)   port4_input_gate_reg      <= wbyte;  // [RULE17]
            if (idx == IDX_P5_LATCH)  port5_out_latch_reg       <= wbyte[3:0];
            if (idx == IDX_P5_DIR)    port5_direction_reg       <= wbyte[3:0];
            if (idx == IDX_CONV_CTL1) converter_control_one_reg <= wbyte;
        end
    end

    // port1 value: latch, anded with the peripheral output on bits 2, 3, 6, 7; a one in the
    // latch hands the pin over, a zero pulls it low
    always_comb begin
        p1_value    = port1_out_latch_reg;  // [RULE10]
        p1_value[2] = port1_out_latch_reg[2] & (periph_drive.timer4_out_sel
                    ? periph_drive.timer4_divider_out
                    : periph_drive.timer4_pulse_width_out);  // [RULE10]
        p1_value[3] = port1_out_latch_reg[3] & periph_drive.pulse_pattern_out; // [RULE10]
        p1_value[6] = port1_out_latch_reg[6] & periph_drive.serial_data_out;   // [RULE11]
        p1_value[7] = port1_out_latch_reg[7] & periph_drive.serial_clock_out_n;// [RULE11]
    end

    // port2 drive: open drain; resonator and stop override the enable
    always_comb begin
        p2_value   = port2_out_latch_reg;
        p2_oe_next = ~port2_out_latch_reg;
        if (dual_clock_mode) begin
            p2_oe_next[2:1] = 2'b00;  // [RULE14]
        end
        if (stop_mode) begin
            p2_oe_next[0] = 1'b0;  // [RULE15]
        end
    end

    // port5 bit3 carries the divider output when set as output
    always_comb begin
        p5_value    = port5_out_latch_reg;
        p5_value[3] = port5_out_latch_reg[3] & periph_drive.divider_out_n;  // [RULE22]
    end

    // pin drive registers; a pin moves one edge after its latch,
    // in the cycle after the second state of the write
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p0_out       <= 8'h00;
            p0_oe        <= 8'h00;
            p1_out       <= 8'h00;
            p1_oe        <= 8'h00;
            p2_out       <= 3'h0;
            p2_oe        <= 3'h0;
            p3_out       <= 2'h0;
            p3_oe        <= 2'h0;
            p4_out       <= 8'h00;
            p4_oe        <= 8'h00;
            p4_gate_open <= 8'h00;
            p5_out       <= 4'h0;
            p5_oe        <= 4'h0;
        end else begin
            p0_out       <= port0_out_latch_reg;  // [RULE3]
            p0_oe        <= port0_direction_reg;  // [RULE4]
            p1_out       <= p1_value;  // [RULE3]
            p1_oe        <= port1_drive_type_reg | ~p1_value;  // [RULE7]
            p2_out       <= p2_value;
            p2_oe        <= p2_oe_next;
            p3_out       <= port3_out_latch_reg;
            p3_oe        <= ~port3_out_latch_reg;  // [RULE16]
            p4_out       <= port4_out_latch_reg;
            p4_oe        <= port4_direction_reg;  // [RULE17]
            p4_gate_open <= port4_input_gate_reg;  // [RULE20]
            p5_out       <= p5_value;
            p5_oe        <= port5_direction_reg;  // [RULE21]
        end
    end

    // peripheral input taps from synchronised pins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            periph_sense         <= '0;
            analog_input_disable <= RST_CONV_CTL1[AIN_DIS_BIT];
        end else begin
            periph_sense.timer2_input      <= p1_pin[0];  // [RULE10]
            periph_sense.timer3_input      <= p1_pin[1]
                                            ^ timer3_input_polarity_reg[T3_INV_BIT]; // [RULE9]
            periph_sense.ext_irq3          <= p1_pin[1];
            periph_sense.timer4_input      <= p1_pin[2];
            periph_sense.ext_irq4          <= p1_pin[4];
            periph_sense.serial_data_in    <= p1_pin[5];  // [RULE11]
            periph_sense.serial_clock_in_n <= p1_pin[7];
            periph_sense.ext_irq0          <= p5_pin[0];  // [RULE22]
            periph_sense.ext_irq1          <= p5_pin[1];
            periph_sense.ext_irq2          <= p5_pin[2];
            periph_sense.timer1_input      <= p5_pin[2];
            analog_input_disable <= converter_control_one_reg[AIN_DIS_BIT];
        end
    end

endmodule

// >>> bench/mpp_pin_model.sv
// far side of the port pins: outside drivers and pull-ups
`timescale 1ns/1ns
module mpp_pin_model (
    input  wire logic [32:0] pin_out, // design drive values
    input  wire logic [32:0] pin_oe,  // design drive enables
    input  wire logic [32:0] ext_val, // outside drive values
    input  wire logic [32:0] ext_en,  // outside driver present
    output logic      [32:0] pin_in   // resolved pin level
);
    // outside only drives pins the design leaves alone; undriven pins float high
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (ext_val | ~ext_en));
endmodule

// >>> bench/mpp_port_group_properties.sv
// assertions on the port group's bus answers and pin drive
`timescale 1ns/1ns
module mpp_port_group_properties
    import mpp_pkg::*;
(
    input wire logic        mclk,            // clock
    input wire logic        rst_n,           // reset, active low
    input wire logic        psel,            // select
    input wire logic        penable,         // access phase
    input wire logic        pwrite,          // write
    input wire logic [11:0] paddr,           // byte address
    input wire logic [31:0] pwdata,          // write data
    input wire logic [31:0] prdata,          // read data
    input wire logic        pready,          // done
    input wire logic        stop_mode,       // stop mode
    input wire logic        dual_clock_mode, // resonator fitted
    input wire logic [7:0]  p0_out,          // port0 value
    input wire logic [7:0]  p0_oe,           // port0 enable
    input wire logic [2:0]  p2_oe,           // port2 enable
    input wire logic [1:0]  p3_out,          // port3 value
    input wire logic [1:0]  p3_oe,           // port3 enable
    input wire logic [7:0]  p4_gate_open     // port4 gate
);
    logic       wr_done;
    logic       rd_ans;
    logic [9:0] idx;
    logic [7:0] wd8;
    // completed write, read answer, register index
    assign wr_done = psel && penable && pready && pwrite;
    assign rd_ans  = pready && !pwrite;
    assign idx     = paddr[11:2];
    assign wd8     = pwdata[7:0];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_ready_first; psel && !penable |=> pready; endproperty
    a_ready_first: assert property (p_ready_first) else $error("ready late");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready stuck");
    property p_latch_out; wr_done && idx == IDX_P0_LATCH |=> ##1 p0_out == $past(wd8, 2); endproperty
    a_latch_out: assert property (p_latch_out) else $error("port0 value late");
    property p_dir_oe; wr_done && idx == IDX_P0_DIR |=> ##1 p0_oe == $past(wd8, 2); endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("port0 enable wrong");
    property p_stop_hiz; stop_mode && $past(stop_mode) |-> !p2_oe[0]; endproperty
    a_stop_hiz: assert property (p_stop_hiz) else $error("stop pin driven");
    property p_resonator; dual_clock_mode && $past(dual_clock_mode) |-> p2_oe[2:1] == 2'b00; endproperty
    a_resonator: assert property (p_resonator) else $error("resonator pins driven");
    property p_p2_upper; rd_ans && (idx == IDX_P2_LATCH || idx == IDX_P2_SENSE) |-> prdata[31:3] == 0; endproperty
    a_p2_upper: assert property (p_p2_upper) else $error("port2 upper bits set");
    property p_gate_read; rd_ans && idx == IDX_P4_GATE |-> prdata[7:0] == p4_gate_open; endproperty
    a_gate_read: assert property (p_gate_read) else $error("gate read wrong");
    property p_p3_drain; $past(rst_n) |-> p3_oe == ~p3_out; endproperty
    a_p3_drain: assert property (p_p3_drain) else $error("port3 drives high");
    // main scenarios reached
    c_write: cover property (wr_done && idx == IDX_P0_DIR);
    c_modes: cover property (stop_mode && dual_clock_mode);
    c_gate: cover property (rd_ans && idx == IDX_P4_GATE && p4_gate_open != 8'hFF);
endmodule
bind mpp_port_group mpp_port_group_properties mpp_port_group_properties_i (.mclk, .rst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .stop_mode,
    .dual_clock_mode, .p0_out, .p0_oe, .p2_oe, .p3_out, .p3_oe, .p4_gate_open);

// >>> bench/mpp_port_group_test.sv
// self-checking bench for the parallel port group
`timescale 1ns/1ns
module mpp_port_group_test;
    import mpp_pkg::*;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic              stop_mode = 1'b0;
    logic              dual_clock_mode = 1'b0;
    logic              pready, pslverr, aid, er;
    logic [11:0]       paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata, rd;
    wire  [32:0]       pin_out, pin_oe, pin_in;
    logic [32:0]       e_val, e_oe;
    logic [32:0]       ext_val = '0;
    logic [32:0]       ext_en = '0;
    logic [7:0]        p4_gate_open;
    logic [7:0]        sh [13];
    mpp_periph_drive_t pd = '0;
    mpp_periph_sense_t ps;
    int                error_cnt = 0;
    int                n_checks = 0;
    int                cyc = 0;
    // read order; sh shadows the first 13
    logic [9:0] ridx [16] = '{IDX_P0_LATCH, IDX_P1_LATCH, IDX_P2_LATCH, IDX_P3_LATCH,
        IDX_P4_LATCH, IDX_P5_LATCH, IDX_P0_DIR, IDX_P1_DRIVE, IDX_P4_DIR, IDX_P5_DIR,
        IDX_CONV_CTL1, IDX_P4_GATE, IDX_T3_POL, IDX_P1_SENSE, IDX_P2_SENSE, IDX_P3_SENSE};
    logic [7:0] msk [13] = '{8'hFF, 8'hFF, 8'h07, 8'h03, 8'hFF, 8'h0F, 8'hFF, 8'hFF,
        8'hFF, 8'h0F, 8'h10, 8'hFF, 8'h01};
    mpp_port_group mpp_port_group_i (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .stop_mode, .dual_clock_mode,
        .p0_in(pin_in[7:0]), .p0_out(pin_out[7:0]), .p0_oe(pin_oe[7:0]),
        .p1_in(pin_in[15:8]), .p1_out(pin_out[15:8]), .p1_oe(pin_oe[15:8]),
        .p2_in(pin_in[18:16]), .p2_out(pin_out[18:16]), .p2_oe(pin_oe[18:16]),
        .p3_in(pin_in[20:19]), .p3_out(pin_out[20:19]), .p3_oe(pin_oe[20:19]),
        .p4_in(pin_in[28:21]), .p4_out(pin_out[28:21]), .p4_oe(pin_oe[28:21]),
        .p5_in(pin_in[32:29]), .p5_out(pin_out[32:29]), .p5_oe(pin_oe[32:29]),
        .p4_gate_open, .periph_drive(pd), .periph_sense(ps), .analog_input_disable(aid));
    mpp_pin_model mpp_pin_model_i (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);
    // 100 MHz clock
    always #5 mclk = ~mclk;
    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; only the hang guard ends the wait
    task automatic xfer(input logic [9:0] idx, input logic wr, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // expected pin levels
    function automatic logic [32:0] exp_pins();
        logic [7:0] v1;
        v1 = sh[1] & {pd.serial_clock_out_n, pd.serial_data_out, 2'b11, pd.pulse_pattern_out,
            pd.timer4_out_sel ? pd.timer4_divider_out : pd.timer4_pulse_width_out, 2'b11};
        e_val = {sh[5][3:0] & {pd.divider_out_n, 3'h7}, sh[4], sh[3][1:0], sh[2][2:0], v1, sh[0]};
        e_oe = {sh[9][3:0], sh[8], ~sh[3][1:0],
            ~sh[2][2:0] & {~dual_clock_mode, ~dual_clock_mode, ~stop_mode}, sh[7] | ~v1, sh[6]};
        return (e_oe & e_val) | (~e_oe & (ext_val | ~ext_en));
    endfunction
    function automatic logic [31:0] rd_exp(int k, logic [32:0] p);
        case (k)
            0: return 32'((sh[6] & sh[0]) | (~sh[6] & p[7:0]));
            4: return 32'((sh[8] & sh[4]) | (~sh[8] & p[28:21] & sh[11]));
            5: return 32'((sh[9][3:0] & sh[5][3:0]) | (~sh[9][3:0] & p[32:29]));
            13: return 32'(p[15:8]);
            14: return 32'(p[18:16]);
            15: return 32'(p[20:19]);
            default: return 32'(sh[k]);
        endcase
    endfunction
    // settle, check pins, taps, reads
    task automatic check_all();
        logic [32:0] p;
        repeat (6) @(posedge mclk);
        p = exp_pins();
        chk(40'(pin_out), 40'(e_val), "pin value");
        chk(40'(pin_oe), 40'(e_oe), "pin enable");
        chk(40'({ps, aid, p4_gate_open}), 40'({p[8], p[9] ^ sh[12][0], p[9], p[10], p[12],
            p[13], p[15], p[29], p[30], p[31], p[31], sh[10][4], sh[11]}), "taps");
        for (int k = 0; k < 16; k++) begin
            xfer(ridx[k], 1'b0, 8'h00);
            chk(40'({er, rd}), 40'(rd_exp(k, p)), "read");
        end
    endtask
    initial begin
        logic [32:0] p;
        void'($urandom(7));
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        sh = '{RST_P0_LATCH, RST_P1_LATCH, 8'(RST_P2_LATCH), 8'(RST_P3_LATCH), RST_P4_LATCH,
            8'(RST_P5_LATCH), RST_P0_DIR, RST_P1_DRIVE, RST_P4_DIR, 8'(RST_P5_DIR),
            RST_CONV_CTL1, RST_P4_GATE, RST_T3_POL};
        check_all();
        $display("test reset values done");
        // random setups; direction written before gate
        repeat (25) begin
            @(posedge mclk);
            ext_val <= {1'($urandom), 32'($urandom)};
            ext_en <= {1'($urandom), 32'($urandom)};
            pd <= mpp_periph_drive_t'(7'($urandom));
            stop_mode <= 1'($urandom);
            dual_clock_mode <= 1'($urandom);
            for (int k = 0; k < 13; k++) begin
                sh[k] = 8'($urandom) & msk[k];
                xfer(ridx[k], 1'b1, sh[k]);
            end
            check_all();
        end
        $display("test random done");
        // read-modify-write picks up input pin levels
        p = exp_pins();
        xfer(IDX_P0_LATCH, 1'b0, 8'h00);
        sh[0] = (sh[6] & sh[0]) | (~sh[6] & p[7:0]);
        xfer(IDX_P0_LATCH, 1'b1, rd[7:0]);
        check_all();
        $display("test read-modify-write done");
        // unmapped word is refused and changes nothing
        xfer(10'h3FF, 1'b1, 8'hA5);
        xfer(10'h3FF, 1'b0, 8'h00);
        chk(40'({er, rd}), 40'({1'b1, 32'h0}), "unmapped");
        check_all();
        $display("test unmapped done");
        finish_test();
    end
endmodule
